//--- core/fcp_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// (R1) Low transmit input drives bus dominant, high leaves it recessive.
// (R2) Receive output low while bus dominant, high while recessive.
// (R3) In Normal mode the error flag goes low on a wiring failure.
// (R4) Transmit input dominant past timeout disables both line drivers.
// (R5) A wiring failure switches to single-wire mode on the intact line.
// (R6) Normal mode without failures uses the differential line pair.
// (R7) Wake edge in low power pulls receive low; from Sleep, inhibit goes high.
// (R8) Both rising and falling wake input edges count as wake-up.
// (R9) Bit timing supports rates up to 125 kBaud; controller stays below it.
// (R10) High-line termination is switched off when the high line fails.
// (R11) Low-line termination follows both failure state and operating mode.
// (R12) Mode is chosen from the not-standby and transfer-enable inputs.
// (R13) Bus wake-up works under every line failure condition.
// (R14) Controller raises both mode inputs to reach Normal after wake-up.
// (R15) Receive-Only passes bus data to receive output, never transmits.
// (R16) Controller holds Go-to-Sleep for the minimum hold time first.
// (R17) Differential mode returns only after an exit delay once failure clears.
// (R18) Dominant timeout clears when the transmit input returns recessive.
// (R19) Delays and timeout are sampling-clock counters reset at power-up.
module fcp_ctrl
  import fcp_pkg::*;
#(
  parameter int unsigned TXD_TIMEOUT = TXD_TIMEOUT_CYC,
  parameter int unsigned FAIL_ENTRY = FAIL_ENTRY_CYC,
  parameter int unsigned FAIL_EXIT = FAIL_EXIT_CYC,
  parameter int unsigned SLEEP_HOLD = SLEEP_HOLD_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic txd_in,
  input wire logic not_standby_in,
  input wire logic transfer_enable_in,
  input wire logic wake_input,
  input wire logic canh_dominant_in,
  input wire logic canl_dominant_in,
  input wire logic canh_failure_in,
  input wire logic canl_failure_in,
  output logic rxd_out,
  output logic error_flag_n,
  output logic regulator_inhibit_out,
  output logic canh_drive,
  output logic canl_drive,
  output logic high_line_termination,
  output logic low_line_termination,
  output logic low_term_to_battery,
  output logic irq
);

  fcp_pins_t pin_raw, pin_m_r, pin_s_r;
  fcp_mode_t mode_r, mode_nxt;
  logic wake_prev_r, wake_r, pwrup_flag_r, to_r, ctrl_fm_en_r;
  logic [CNT_W-1:0] to_cnt_r, hold_cnt_r;
  logic [1:0] fail_r, fail_raw;
  logic [CNT_W-1:0] fail_cnt_r [2];
  logic [NUM_EV-1:0] irq_stat_r, irq_en_r, irq_ev, irq_clr, irq_stat_nxt;
  logic wake_edge, low_power, bus_dom, bus_wake, tx_dom;
  logic aw_have_r, w_have_r, do_write;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  function automatic logic [31:0] read_mux(input logic [7:0] a, input logic [31:0] st);
    case (a)
      CTRL_OFS: read_mux = {31'h0, ctrl_fm_en_r};
      STATUS_OFS: read_mux = st;
      IRQ_STAT_OFS: read_mux = {28'h0, irq_stat_r};
      IRQ_EN_OFS: read_mux = {28'h0, irq_en_r};
      default: read_mux = 32'h0;
    endcase
  endfunction : read_mux

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == CTRL_OFS) || (a == STATUS_OFS) || (a == IRQ_STAT_OFS) ||
             (a == IRQ_CLR_OFS) || (a == IRQ_EN_OFS);
  endfunction : mapped

  // Pins are asynchronous to aclk: two flops before any use
  assign pin_raw = '{txd: txd_in, not_standby: not_standby_in,
                     transfer_en: transfer_enable_in, wake: wake_input,
                     canh_dom: canh_dominant_in, canl_dom: canl_dominant_in,
                     canh_fail: canh_failure_in, canl_fail: canl_failure_in};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_m_r <= '0;
      pin_s_r <= '0;
      wake_prev_r <= 1'b0;
    end else begin
      pin_m_r <= pin_raw;
      pin_s_r <= pin_m_r; // R9
      wake_prev_r <= pin_s_r.wake;
    end
  end

  // Reset takes wake_prev low, so a wake pin resting high gives one edge, which sets wake_r as a wake-up in Standby
  assign wake_edge = pin_s_r.wake != wake_prev_r; // R8
  assign low_power = (mode_r == M_STANDBY) || (mode_r == M_SLEEP) || (mode_r == M_GOSLEEP);
  assign bus_wake = pin_s_r.canh_dom || pin_s_r.canl_dom; // R13

  always_comb begin
    mode_nxt = mode_r;
    case ({pin_s_r.not_standby, pin_s_r.transfer_en}) // R12
      2'b11: mode_nxt = M_NORMAL;
      2'b10: mode_nxt = M_RXONLY;
      2'b01: begin
        if (mode_r == M_SLEEP) begin
          mode_nxt = M_SLEEP;
        end else if (mode_r == M_GOSLEEP && hold_cnt_r >= CNT_W'(SLEEP_HOLD)) begin
          mode_nxt = M_SLEEP;
        end else begin
          mode_nxt = M_GOSLEEP;
        end
      end
      2'b00: begin
        // Transfer-enable may drop as supply fades after Go-to-Sleep
        if (mode_r == M_SLEEP || (mode_r == M_GOSLEEP && hold_cnt_r >= CNT_W'(SLEEP_HOLD))) begin
          mode_nxt = M_SLEEP;
        end else begin
          mode_nxt = M_STANDBY;
        end
      end
      default: mode_nxt = mode_r;
    endcase
    if (mode_r == M_SLEEP && (wake_edge || bus_wake)) begin
      mode_nxt = M_STANDBY; // R7
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= M_STANDBY;
      hold_cnt_r <= '0;
    end else begin
      mode_r <= mode_nxt;
      if (mode_r != M_GOSLEEP) begin
        hold_cnt_r <= '0;
      end else if (hold_cnt_r < CNT_W'(SLEEP_HOLD)) begin
        hold_cnt_r <= hold_cnt_r + 1'b1; // R19
      end
    end
  end

  // Wake request and power-up flag; set and clear never share a mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_r <= 1'b0;
      pwrup_flag_r <= 1'b1;
    end else begin
      if (mode_r == M_NORMAL) begin
        wake_r <= 1'b0;
        pwrup_flag_r <= 1'b0;
      end else if (low_power && (wake_edge || bus_wake)) begin
        wake_r <= 1'b1; // R7 R8 R13
      end
    end
  end

  // Dominant timeout guards against a stuck controller
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      to_cnt_r <= '0;
      to_r <= 1'b0;
    end else if (pin_s_r.txd) begin
      to_cnt_r <= '0;
      to_r <= 1'b0; // R18
    end else if (to_cnt_r >= CNT_W'(TXD_TIMEOUT - 1)) begin
      to_r <= 1'b1; // R4
    end else begin
      to_cnt_r <= to_cnt_r + 1'b1; // R19
    end
  end

  // Failure filters: entry and exit delays reject RF glitches
  assign fail_raw = {pin_s_r.canl_fail, pin_s_r.canh_fail} & {2{ctrl_fm_en_r}};

  generate
    for (genvar i = 0; i < 2; i++) begin : g_fail
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          fail_cnt_r[i] <= '0;
          fail_r[i] <= 1'b0;
        end else if (fail_raw[i] == fail_r[i]) begin
          fail_cnt_r[i] <= '0;
        end else if (fail_cnt_r[i] >= CNT_W'((fail_raw[i] ? FAIL_ENTRY : FAIL_EXIT) - 1)) begin
          fail_cnt_r[i] <= '0;
          fail_r[i] <= fail_raw[i]; // R5 R17
        end else begin
          fail_cnt_r[i] <= fail_cnt_r[i] + 1'b1; // R19
        end
      end
    end
  endgenerate

  // Single-wire reception on the intact line, differential otherwise
  always_comb begin
    if (fail_r[LINE_H]) begin
      bus_dom = pin_s_r.canl_dom; // R5
    end else if (fail_r[LINE_L]) begin
      bus_dom = pin_s_r.canh_dom; // R5
    end else begin
      bus_dom = pin_s_r.canh_dom && pin_s_r.canl_dom; // R6
    end
  end

  assign tx_dom = !pin_s_r.txd && (mode_r == M_NORMAL) && !to_r; // R1 R4 R15

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_out <= 1'b1;
      error_flag_n <= 1'b1;
      regulator_inhibit_out <= 1'b1;
      canh_drive <= 1'b0;
      canl_drive <= 1'b0;
      high_line_termination <= 1'b1;
      low_line_termination <= 1'b1;
      low_term_to_battery <= 1'b1;
    end else begin
      rxd_out <= low_power ? !wake_r : !bus_dom; // R2 R7 R15
      if (mode_r == M_NORMAL) begin
        error_flag_n <= !(|fail_r); // R3
      end else if (mode_r == M_RXONLY) begin
        error_flag_n <= !pwrup_flag_r;
      end else begin
        error_flag_n <= !wake_r;
      end
      regulator_inhibit_out <= (mode_r != M_SLEEP); // R7
      canh_drive <= tx_dom && !fail_r[LINE_H]; // R1 R5
      canl_drive <= tx_dom && !fail_r[LINE_L]; // R1 R5
      high_line_termination <= !fail_r[LINE_H]; // R10
      low_line_termination <= !fail_r[LINE_L]; // R11
      low_term_to_battery <= low_power; // R11
    end
  end

  // Interrupts: sticky status, write-one-to-clear, set beats clear
  assign irq_ev[EV_WAKE] = low_power && (wake_edge || bus_wake) && !wake_r;
  assign irq_ev[EV_FAIL_H] = fail_raw[LINE_H] && !fail_r[LINE_H] &&
                             fail_cnt_r[LINE_H] >= CNT_W'(FAIL_ENTRY - 1);
  assign irq_ev[EV_FAIL_L] = fail_raw[LINE_L] && !fail_r[LINE_L] &&
                             fail_cnt_r[LINE_L] >= CNT_W'(FAIL_ENTRY - 1);
  assign irq_ev[EV_TIMEOUT] = !pin_s_r.txd && !to_r && to_cnt_r >= CNT_W'(TXD_TIMEOUT - 1);
  assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
  assign irq_clr = (do_write && awaddr_r == IRQ_CLR_OFS && wstrb_r[0]) ?
                   wdata_r[NUM_EV-1:0] : '0;
  assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_ev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq <= |(irq_stat_nxt & irq_en_r);
    end
  end

  // AXI4-Lite write side: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (do_write) begin
        w_have_r <= 1'b0;
      end
      s_axi_awready <= !(aw_have_r || (s_axi_awvalid && s_axi_awready)) || do_write;
      s_axi_wready <= !(w_have_r || (s_axi_wvalid && s_axi_wready)) || do_write;
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_fm_en_r <= CTRL_RST;
      irq_en_r <= IRQ_EN_RST;
    end else if (do_write && wstrb_r[0]) begin
      if (awaddr_r == CTRL_OFS) begin
        ctrl_fm_en_r <= wdata_r[0];
      end
      if (awaddr_r == IRQ_EN_OFS) begin
        irq_en_r <= wdata_r[NUM_EV-1:0];
      end
    end
  end

  // AXI4-Lite read side: one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= read_mux(s_axi_araddr,
                               {22'h0, to_r, fail_r, wake_r, pwrup_flag_r, mode_r});
        s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        s_axi_arready <= 1'b0;
      end else begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
        s_axi_arready <= !s_axi_rvalid || s_axi_rready;
      end
    end
  end

  property p_tx_dom;
    @(posedge aclk) disable iff (!aresetn)
      (mode_r == M_NORMAL && !to_r && fail_r == 2'h0 && !pin_s_r.txd)
      |=> (canh_drive && canl_drive);
  endproperty
  a_tx_dom: assert property (p_tx_dom) else $error("dominant transmit not driven"); // R1

  property p_rx_dom;
    @(posedge aclk) disable iff (!aresetn)
      (mode_r == M_NORMAL && pin_s_r.canh_dom && pin_s_r.canl_dom) |=> !rxd_out;
  endproperty
  a_rx_dom: assert property (p_rx_dom) else $error("receive not low on dominant bus"); // R2

  property p_err_flag;
    @(posedge aclk) disable iff (!aresetn)
      (mode_r == M_NORMAL && |fail_r) |=> !error_flag_n;
  endproperty
  a_err_flag: assert property (p_err_flag) else $error("error flag not raised"); // R3

  property p_timeout;
    @(posedge aclk) disable iff (!aresetn)
      to_r |=> (!canh_drive && !canl_drive);
  endproperty
  a_timeout: assert property (p_timeout) else $error("drivers active after timeout"); // R4

  property p_single_wire;
    @(posedge aclk) disable iff (!aresetn)
      fail_r[LINE_H] |=> (!canh_drive && !high_line_termination);
  endproperty
  a_single_wire: assert property (p_single_wire) else $error("failed high line still used"); // R5

  property p_wake;
    @(posedge aclk) disable iff (!aresetn)
      (mode_r == M_SLEEP && wake_edge) |=> (mode_r == M_STANDBY && wake_r) ##1
        (!rxd_out && regulator_inhibit_out);
  endproperty
  a_wake: assert property (p_wake) else $error("wake from sleep not signalled"); // R7

  property p_wake_fall;
    @(posedge aclk) disable iff (!aresetn)
      (low_power && $fell(pin_s_r.wake)) |=> wake_r;
  endproperty
  a_wake_fall: assert property (p_wake_fall) else $error("falling wake edge missed"); // R8

  property p_rx_only;
    @(posedge aclk) disable iff (!aresetn)
      (mode_r == M_RXONLY) |=> (!canh_drive && !canl_drive);
  endproperty
  a_rx_only: assert property (p_rx_only) else $error("transmit in receive-only"); // R15

  property p_to_clear;
    @(posedge aclk) disable iff (!aresetn)
      (to_r && pin_s_r.txd) |=> !to_r;
  endproperty
  a_to_clear: assert property (p_to_clear) else $error("timeout not cleared"); // R18

endmodule : fcp_ctrl

`default_nettype wire

//--- shared/fcp_pkg.sv
package fcp_pkg;

  // Sampling clock and timing figures
  localparam int CLK_MHZ = 50;
  localparam int TXD_TIMEOUT_US = 1000;
  localparam int FAIL_ENTRY_US = 40;
  localparam int FAIL_EXIT_US = 200;
  localparam int SLEEP_HOLD_US = 50;
  localparam int TXD_TIMEOUT_CYC = TXD_TIMEOUT_US * CLK_MHZ;
  localparam int FAIL_ENTRY_CYC = FAIL_ENTRY_US * CLK_MHZ;
  localparam int FAIL_EXIT_CYC = FAIL_EXIT_US * CLK_MHZ;
  localparam int SLEEP_HOLD_CYC = SLEEP_HOLD_US * CLK_MHZ;
  localparam int CNT_W = 20;

  // Register map, byte addresses
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h0c;
  localparam logic [7:0] IRQ_EN_OFS = 8'h10;

  localparam logic CTRL_RST = 1'h1;
  localparam logic [3:0] IRQ_EN_RST = 4'h0;
  localparam int NUM_EV = 4;
  localparam int EV_WAKE = 0;
  localparam int EV_FAIL_H = 1;
  localparam int EV_FAIL_L = 2;
  localparam int EV_TIMEOUT = 3;
  localparam int LINE_H = 0;
  localparam int LINE_L = 1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    M_STANDBY = 5'h01,
    M_SLEEP = 5'h02,
    M_GOSLEEP = 5'h04,
    M_RXONLY = 5'h08,
    M_NORMAL = 5'h10
  } fcp_mode_t;

  typedef struct packed {
    logic txd;
    logic not_standby;
    logic transfer_en;
    logic wake;
    logic canh_dom;
    logic canl_dom;
    logic canh_fail;
    logic canl_fail;
  } fcp_pins_t;

endpackage : fcp_pkg

//--- tb/fault_tolerant_can_phy_control_bench.sv
`timescale 1ns/1ps
`default_nettype none

module fault_tolerant_can_phy_control_bench
  import fcp_pkg::*;
;
  localparam int TO = 600;
  logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic txd_in = 1'h1, not_standby_in = 1'h0, transfer_enable_in = 1'h0, wake_input = 1'h0;
  logic canh_failure_in = 1'h0, canl_failure_in = 1'h0, ext_dom = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rxd_out;
  logic error_flag_n, regulator_inhibit_out, canh_drive, canl_drive, irq;
  logic high_line_termination, low_line_termination, low_term_to_battery;
  logic canh_dominant_in, canl_dominant_in;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int bad_count = 0;
  int compares = 0;

  always #10 aclk = ~aclk;

  // Short counts keep the run small; the timeout still exceeds one bit time
  fcp_ctrl #(.TXD_TIMEOUT(TO), .FAIL_ENTRY(5), .FAIL_EXIT(8), .SLEEP_HOLD(6)) DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .txd_in, .not_standby_in,
    .transfer_enable_in, .wake_input, .canh_dominant_in, .canl_dominant_in,
    .canh_failure_in, .canl_failure_in, .rxd_out, .error_flag_n, .regulator_inhibit_out,
    .canh_drive, .canl_drive, .high_line_termination, .low_line_termination,
    .low_term_to_battery, .irq);

  fcp_bus_model BUS (.canh_drive, .canl_drive, .canh_failure_in, .canl_failure_in,
    .ext_dom, .canh_dominant_in, .canl_dominant_in);

  task automatic chk_bit(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk_word

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 100);
    s_axi_bready <= 1'h0;
    if (n >= 100) bad_count++;
    chk_word({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : axi_wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 100);
    s_axi_rready <= 1'h0;
    if (n >= 100) bad_count++;
    chk_word(s_axi_rdata & m, e);
    chk_word({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rd_chk

  // One bit lasts 400 cycles, no faster than the top bus rate
  task automatic tx_bit(input logic v);
    cyc(390);
    txd_in <= v;
    cyc(10);
  endtask : tx_bit

  task automatic mode(input logic ns, input logic te);
    not_standby_in <= ns;
    transfer_enable_in <= te;
    cyc(10);
  endtask : mode

  task automatic fail_case(input int ln);
    if (ln == 0) canh_failure_in <= 1'h1;
    else canl_failure_in <= 1'h1;
    cyc(20);
    chk_bit(error_flag_n, 1'h0);
    chk_bit(high_line_termination, ln[0]);
    chk_bit(low_line_termination, !ln[0]);
    chk_bit(irq, !ln[0]);
    rd_chk(IRQ_STAT_OFS, 32'h6, (ln == 0) ? 32'h2 : 32'h4, RESP_OKAY);
    tx_bit(1'h0);
    chk_bit(canh_drive, ln[0]);
    chk_bit(canl_drive, !ln[0]);
    chk_bit(rxd_out, 1'h0);
    tx_bit(1'h1);
    axi_wr(IRQ_CLR_OFS, 32'h6, RESP_OKAY);
    cyc(2);
    chk_bit(irq, 1'h0);
    canh_failure_in <= 1'h0;
    canl_failure_in <= 1'h0;
    cyc(5);
    chk_bit(error_flag_n, 1'h0);
    cyc(20);
    chk_bit(error_flag_n, 1'h1);
    chk_bit(high_line_termination & low_line_termination, 1'h1);
  endtask : fail_case

  task automatic sw(input int k);
    mode(1'h1, 1'h1);
    mode(1'h0, 1'h1);
    mode(1'h0, 1'h0);
    chk_bit(regulator_inhibit_out, 1'h0);
    chk_bit(low_term_to_battery, 1'h1);
    rd_chk(STATUS_OFS, 32'h1f, 32'h02, RESP_OKAY);
    if (k == 2) begin
      canh_failure_in <= 1'h1;
      ext_dom <= 1'h1;
    end else begin
      wake_input <= ~wake_input;
    end
    cyc(10);
    chk_bit(regulator_inhibit_out, 1'h1);
    chk_bit(rxd_out, 1'h0);
    chk_bit(error_flag_n, 1'h0);
    chk_bit(irq, 1'h1);
    rd_chk(STATUS_OFS, 32'h1f, 32'h01, RESP_OKAY);
    ext_dom <= 1'h0;
    canh_failure_in <= 1'h0;
    axi_wr(IRQ_CLR_OFS, 32'h1, RESP_OKAY);
    cyc(2);
    chk_bit(irq, 1'h0);
  endtask : sw

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  // The tests take about 6000 cycles; a hang ends well inside the run limit
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    results();
  end

  initial begin
    cyc(20);
    aresetn <= 1'h1;
    cyc(2);
    rd_chk(CTRL_OFS, 32'h1, 32'h1, RESP_OKAY);
    rd_chk(IRQ_EN_OFS, 32'hf, 32'h0, RESP_OKAY);
    rd_chk(STATUS_OFS, 32'h3f, 32'h21, RESP_OKAY);
    chk_bit(error_flag_n & regulator_inhibit_out & low_term_to_battery, 1'h1);
    axi_wr(8'h20, 32'h1, RESP_SLVERR);
    rd_chk(8'h20, 32'hffffffff, 32'h0, RESP_SLVERR);
    rd_chk(IRQ_CLR_OFS, 32'hffffffff, 32'h0, RESP_OKAY);
    mode(1'h1, 1'h1);
    rd_chk(STATUS_OFS, 32'h3f, 32'h10, RESP_OKAY);
    chk_bit(low_term_to_battery, 1'h0);
    chk_bit(error_flag_n, 1'h1);
    tx_bit(1'h0);
    chk_bit(canh_drive & canl_drive, 1'h1);
    chk_bit(rxd_out, 1'h0);
    tx_bit(1'h1);
    chk_bit(canh_drive | canl_drive, 1'h0);
    chk_bit(rxd_out, 1'h1);
    ext_dom <= 1'h1;
    cyc(10);
    chk_bit(rxd_out, 1'h0);
    ext_dom <= 1'h0;
    axi_wr(IRQ_EN_OFS, 32'h2, RESP_OKAY);
    tx_bit(1'h0);
    cyc(TO + 100);
    chk_bit(canh_drive | canl_drive, 1'h0);
    rd_chk(STATUS_OFS, 32'h200, 32'h200, RESP_OKAY);
    rd_chk(IRQ_STAT_OFS, 32'hf, 32'h8, RESP_OKAY);
    chk_bit(irq, 1'h0);
    tx_bit(1'h1);
    tx_bit(1'h0);
    chk_bit(canh_drive & canl_drive, 1'h1);
    tx_bit(1'h1);
    axi_wr(IRQ_CLR_OFS, 32'hf, RESP_OKAY);
    rd_chk(IRQ_STAT_OFS, 32'hf, 32'h0, RESP_OKAY);
    fail_case(0);
    fail_case(1);
    axi_wr(CTRL_OFS, 32'h0, RESP_OKAY);
    canh_failure_in <= 1'h1;
    cyc(20);
    chk_bit(high_line_termination, 1'h1);
    chk_bit(error_flag_n, 1'h1);
    rd_chk(CTRL_OFS, 32'h1, 32'h0, RESP_OKAY);
    canh_failure_in <= 1'h0;
    axi_wr(CTRL_OFS, 32'h1, RESP_OKAY);
    mode(1'h1, 1'h0);
    rd_chk(STATUS_OFS, 32'h1f, 32'h08, RESP_OKAY);
    chk_bit(low_term_to_battery, 1'h0);
    tx_bit(1'h0);
    chk_bit(canh_drive | canl_drive, 1'h0);
    ext_dom <= 1'h1;
    cyc(10);
    chk_bit(rxd_out, 1'h0);
    ext_dom <= 1'h0;
    tx_bit(1'h1);
    axi_wr(IRQ_EN_OFS, 32'h1, RESP_OKAY);
    for (int k = 0; k < 3; k++) sw(k);
    mode(1'h1, 1'h1);
    cyc(20);
    chk_bit(rxd_out & error_flag_n, 1'h1);
    results();
  end
endmodule : fault_tolerant_can_phy_control_bench

`default_nettype wire

//--- tb/fcp_bus_model.sv
`timescale 1ns/1ps
`default_nettype none

// Two-wire bus with one remote node; a failed wire never shows dominant
module fcp_bus_model (
  input wire logic canh_drive,
  input wire logic canl_drive,
  input wire logic canh_failure_in,
  input wire logic canl_failure_in,
  input wire logic ext_dom,
  output logic canh_dominant_in,
  output logic canl_dominant_in
);
  always_comb begin
    canh_dominant_in = !canh_failure_in && (canh_drive || ext_dom);
    canl_dominant_in = !canl_failure_in && (canl_drive || ext_dom);
  end
endmodule : fcp_bus_model

`default_nettype wire
